// ---- baud_gen.sv ----
// Serial port bit-rate generator with APB registers and receive vote
//
// Functional notes
// RULE_01: 8-bit free-running counter, period set by divisor; async and sync
// RULE_02: Divisor is unsigned 8-bit, every value 0 to 255 valid
// RULE_03: Async mode: high-speed select bit 2 changes the ratio
// RULE_04: Sync mode ignores high-speed select entirely
// RULE_05: Async low speed: rate = clock / (64 * (divisor + 1))
// RULE_06: Async high speed: rate = clock / (16 * (divisor + 1))
// RULE_07: Sync: rate = clock / (4 * (divisor + 1)), no fast variant
// RULE_08: Rates apply only with internal clock; slave uses external clock
// RULE_09: Divisor write restarts counter at once, no overflow wait
// RULE_10: Receive pin sampled three times, level by majority vote
// RULE_11: Software may prefer high speed for lower rate error
// RULE_12: Sync with clock source select set: master, internal clock
// RULE_13: Count down from divisor, reload at zero, then prescale
`timescale 1ns/1ns
`default_nettype none

module baud_gen #(
    parameter int DIV_W = 8
) (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Status from shift logic
    input  wire logic        i_shift_empty,
    input  wire logic [2:0]  i_rx_status,
    // Receive pin
    input  wire logic        i_receive_data_pin,
    // To shift logic
    output logic             o_bit_tick,
    output logic             o_sample_tick,
    output logic             o_rx_level,
    output logic             o_clock_master,
    output logic [7:0]       o_transmit_control,
    output logic [7:0]       o_receive_control
);

    // ======================================================================
    // Parameter check
    if (DIV_W != 8) begin : g_bad_width
        $error("baud_gen: divisor width must be 8");
    end

    // ======================================================================
    // Helpers
    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : maj3

    // ======================================================================
    // Registers
    logic [7:0]        tx_ctrl_r;
    logic [7:0]        rx_ctrl_r;
    logic [DIV_W-1:0]  divisor_r;
    logic [DIV_W-1:0]  cnt_r;
    logic [DIV_W-1:0]  cnt_nxt;
    logic [5:0]        presc_r;
    logic [5:0]        presc_nxt;
    logic [2:0]        win_r;
    logic              pready_r;
    logic              pslverr_r;
    logic [31:0]       prdata_r;
    logic              bit_tick_r;
    logic              sample_tick_r;
    logic              rx_level_r;
    logic              master_r;

    // ======================================================================
    // APB decode
    wire logic        setup_ph;
    wire logic        access_done;
    wire logic        hit_tx;
    wire logic        hit_rx;
    wire logic        hit_div;
    wire logic        addr_hit;
    wire logic        wr_en;
    wire logic        div_wr;
    wire logic [7:0]  tx_read;
    wire logic [7:0]  rx_read;
    wire logic [31:0] rd_data;

    assign setup_ph    = i_psel && !i_penable;
    assign access_done = i_psel && i_penable && pready_r;
    assign hit_tx      = i_paddr == baud_pkg::OFS_TRANSMIT_CONTROL;
    assign hit_rx      = i_paddr == baud_pkg::OFS_RECEIVE_CONTROL;
    assign hit_div     = i_paddr == baud_pkg::OFS_BAUD_DIVISOR;
    assign addr_hit    = hit_tx || hit_rx || hit_div;
    assign wr_en       = access_done && i_pwrite;
    assign div_wr      = wr_en && hit_div;

    // Status bits come live from the shift logic
    assign tx_read = (tx_ctrl_r & baud_pkg::WMASK_TRANSMIT)
                   | {6'h00, i_shift_empty, 1'b0};
    assign rx_read = (rx_ctrl_r & baud_pkg::WMASK_RECEIVE)
                   | {5'h00, i_rx_status};
    assign rd_data = hit_tx  ? {24'h000000, tx_read} :
                     hit_rx  ? {24'h000000, rx_read} :
                     hit_div ? {24'h000000, divisor_r} : 32'h00000000;

    // ======================================================================
    // Mode selection
    wire logic       mode_sync;
    wire logic       high_speed;
    wire logic       clk_src_sel;
    wire logic       internal_clk;
    wire logic [5:0] ratio_m1;
    wire logic       gen_tick;
    wire logic       presc_hit;

    assign mode_sync   = tx_ctrl_r[baud_pkg::BIT_MODE_SYNC];
    assign high_speed  = tx_ctrl_r[baud_pkg::BIT_HIGH_SPEED_SELECT];
    assign clk_src_sel = tx_ctrl_r[baud_pkg::BIT_CLOCK_SOURCE_SELECT];
    // Async always internal; sync only as master
    assign internal_clk = !mode_sync || clk_src_sel;            // [RULE_08]
    // High-speed select only counts in async mode
    assign ratio_m1 = mode_sync  ? baud_pkg::RATIO_SYNC :       // [RULE_04]
                      high_speed ? baud_pkg::RATIO_ASYNC_HIGH : // [RULE_03]
                                   baud_pkg::RATIO_ASYNC_LOW;

    // ======================================================================
    // Divisor counter and prescaler
    assign gen_tick  = cnt_r == '0;                             // [RULE_13]
    // >= so a switch to a shorter ratio never strands the prescaler
    assign presc_hit = gen_tick && (presc_r >= ratio_m1);       // [RULE_05]

    always_comb begin
        if (div_wr) begin
            cnt_nxt = i_pwdata[DIV_W-1:0];                      // [RULE_09]
        end else if (gen_tick) begin
            cnt_nxt = divisor_r;                                // [RULE_01]
        end else begin
            cnt_nxt = cnt_r - 1'b1;                             // [RULE_13]
        end
    end

    always_comb begin
        if (div_wr || presc_hit) begin
            presc_nxt = 6'h00;                                  // [RULE_09]
        end else if (gen_tick) begin
            presc_nxt = presc_r + 6'h01;                        // [RULE_06]
        end else begin
            presc_nxt = presc_r;
        end
    end

    // ======================================================================
    // Register file and APB answer
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            tx_ctrl_r <= baud_pkg::RST_TRANSMIT_CONTROL;
            rx_ctrl_r <= baud_pkg::RST_RECEIVE_CONTROL;
            divisor_r <= baud_pkg::RST_BAUD_DIVISOR;
        end else if (wr_en) begin
            if (hit_tx) begin
                tx_ctrl_r <= i_pwdata[7:0] & baud_pkg::WMASK_TRANSMIT;
            end
            if (hit_rx) begin
                rx_ctrl_r <= i_pwdata[7:0] & baud_pkg::WMASK_RECEIVE;
            end
            if (hit_div) begin
                divisor_r <= i_pwdata[DIV_W-1:0];               // [RULE_02]
            end
        end
    end

    // One wait-free answer: ready is registered from the setup cycle, high in the first access cycle
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= setup_ph;
            pslverr_r <= setup_ph && !addr_hit;
            prdata_r  <= (setup_ph && !i_pwrite) ? rd_data : 32'h00000000;
        end
    end

    // ======================================================================
    // Generator state
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cnt_r   <= '0;
            presc_r <= 6'h00;
        end else begin
            cnt_r   <= cnt_nxt;
            presc_r <= presc_nxt;
        end
    end

    // Ticks reach the shift logic only when this end makes the clock
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            bit_tick_r    <= 1'b0;
            sample_tick_r <= 1'b0;
            master_r      <= 1'b0;
        end else begin
            bit_tick_r    <= presc_hit && internal_clk;         // [RULE_07]
            sample_tick_r <= gen_tick && internal_clk;
            master_r      <= mode_sync && clk_src_sel;          // [RULE_12]
        end
    end

    // ======================================================================
    // Receive majority vote, one sample per generator tick
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            win_r      <= 3'h7;
            rx_level_r <= 1'b1;
        end else begin
            if (gen_tick) begin
                win_r <= {win_r[1:0], i_receive_data_pin};      // [RULE_10]
            end
            rx_level_r <= maj3(win_r);                          // [RULE_10]
        end
    end

    // ======================================================================
    // Outputs
    assign o_prdata           = prdata_r;
    assign o_pready           = pready_r;
    assign o_pslverr          = pslverr_r;
    assign o_bit_tick         = bit_tick_r;
    assign o_sample_tick      = sample_tick_r;
    assign o_rx_level         = rx_level_r;
    assign o_clock_master     = master_r;
    assign o_transmit_control = tx_ctrl_r;
    assign o_receive_control  = rx_ctrl_r;

    // ======================================================================
    // Assertions
    property p_reload;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (gen_tick && !div_wr) |=> cnt_r == $past(divisor_r);
    endproperty
    a_reload: assert property (p_reload) // [RULE_01]
        else $error("counter did not reload divisor");

    property p_zero_div;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (divisor_r == 8'h00 && gen_tick && !div_wr) |=> gen_tick;
    endproperty
    a_zero_div: assert property (p_zero_div) // [RULE_02]
        else $error("divisor zero did not tick every cycle");

    property p_async_ratio;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !mode_sync |-> ratio_m1 == (high_speed ? 6'h0f : 6'h3f);
    endproperty
    a_async_ratio: assert property (p_async_ratio) // [RULE_03]
        else $error("async ratio not set by high-speed select");

    property p_sync_ratio;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        mode_sync |-> ratio_m1 == 6'h03;
    endproperty
    a_sync_ratio: assert property (p_sync_ratio) // [RULE_04]
        else $error("sync ratio depends on high-speed select");

    property p_low_tick;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (o_bit_tick && $past(!mode_sync && !high_speed))
            |-> $past(presc_r) == 6'h3f && $past(gen_tick);
    endproperty
    a_low_tick: assert property (p_low_tick) // [RULE_05]
        else $error("async low bit tick not after 64 counts");

    property p_high_tick;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (o_bit_tick && $past(!mode_sync && high_speed))
            |-> $past(presc_r) >= 6'h0f && $past(gen_tick);
    endproperty
    a_high_tick: assert property (p_high_tick) // [RULE_06]
        else $error("async high bit tick not after 16 counts");

    property p_sync_tick;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (o_bit_tick && $past(mode_sync))
            |-> $past(presc_r) >= 6'h03 && $past(gen_tick);
    endproperty
    a_sync_tick: assert property (p_sync_tick) // [RULE_07]
        else $error("sync bit tick not after 4 counts");

    property p_slave_quiet;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (mode_sync && !clk_src_sel) |=> !o_bit_tick && !o_sample_tick;
    endproperty
    a_slave_quiet: assert property (p_slave_quiet) // [RULE_08]
        else $error("ticks issued in slave mode");

    property p_div_restart;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        div_wr |=> cnt_r == $past(i_pwdata[7:0]) && presc_r == 6'h00
                   && divisor_r == $past(i_pwdata[7:0]);
    endproperty
    a_div_restart: assert property (p_div_restart) // [RULE_09]
        else $error("divisor write did not restart generator");

    property p_vote;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        1'b1 |=> o_rx_level == maj3($past(win_r));
    endproperty
    a_vote: assert property (p_vote) // [RULE_10]
        else $error("receive level is not the majority");

    property p_master;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (mode_sync && clk_src_sel) |=> o_clock_master;
    endproperty
    a_master: assert property (p_master) // [RULE_12]
        else $error("sync master flag missing");

    property p_count_down;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!gen_tick && !div_wr) |=> cnt_r == $past(cnt_r) - 8'h01;
    endproperty
    a_count_down: assert property (p_count_down) // [RULE_13]
        else $error("counter did not count down");

    property p_cov_low;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        o_bit_tick && !mode_sync && !high_speed;
    endproperty
    c_cov_low: cover property (p_cov_low);

    property p_cov_high;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        o_bit_tick && !mode_sync && high_speed;
    endproperty
    c_cov_high: cover property (p_cov_high);

    property p_cov_sync;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        o_bit_tick && mode_sync;
    endproperty
    c_cov_sync: cover property (p_cov_sync);

    property p_cov_wr;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        div_wr && cnt_r != 8'h00;
    endproperty
    c_cov_wr: cover property (p_cov_wr);

endmodule : baud_gen

`default_nettype wire

// ---- baud_pkg.sv ----
// Constants for the serial port bit-rate generator and its register map
`default_nettype none

package baud_pkg;

    // ======================================================================
    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_TRANSMIT_CONTROL = 8'h00;
    localparam logic [7:0] OFS_RECEIVE_CONTROL  = 8'h04;
    localparam logic [7:0] OFS_BAUD_DIVISOR     = 8'h08;

    // ======================================================================
    // Reset values
    localparam logic [7:0] RST_TRANSMIT_CONTROL = 8'h02;
    localparam logic [7:0] RST_RECEIVE_CONTROL  = 8'h00;
    localparam logic [7:0] RST_BAUD_DIVISOR     = 8'h00;

    // ======================================================================
    // Writable bits; the rest are status or read as zero
    localparam logic [7:0] WMASK_TRANSMIT = 8'hf5;
    localparam logic [7:0] WMASK_RECEIVE  = 8'hf8;

    // ======================================================================
    // Field positions
    localparam int BIT_CLOCK_SOURCE_SELECT = 7;
    localparam int BIT_MODE_SYNC           = 4;
    localparam int BIT_HIGH_SPEED_SELECT   = 2;
    localparam int BIT_SHIFT_EMPTY         = 1;
    localparam int BIT_SERIAL_ENABLE       = 7;

    // ======================================================================
    // Prescale ratios minus one: async low, async high, sync
    localparam int          PRESC_W         = 6;
    localparam logic [5:0]  RATIO_ASYNC_LOW  = 6'h3f;
    localparam logic [5:0]  RATIO_ASYNC_HIGH = 6'h0f;
    localparam logic [5:0]  RATIO_SYNC       = 6'h03;

endpackage : baud_pkg

`default_nettype wire

// ---- shift_logic_model.sv ----
// Behavioural model of the serial shift logic fed by the generator ticks
`timescale 1ns/1ns
`default_nettype none

module shift_logic_model (
    // Clock
    input  wire logic       i_sys_clk,
    // From generator and bench
    input  wire logic       i_bit_tick,
    input  wire logic       i_start,
    input  wire logic [2:0] i_err,
    // Status back to the generator
    output logic            o_shift_empty,
    output logic [2:0]      o_rx_status
);
    // ==================================================================
    // Shifter
    logic [3:0] bits_left_r = 4'h0;

    // One bit leaves per bit tick, so empty only shows after eight ticks
    always_ff @(posedge i_sys_clk) begin
        if (i_start)
            bits_left_r <= 4'h8;
        else if (i_bit_tick && bits_left_r != 4'h0)
            bits_left_r <= bits_left_r - 4'h1;
    end

    assign o_shift_empty = (bits_left_r == 4'h0);
    assign o_rx_status   = i_err;
endmodule : shift_logic_model
`default_nettype wire

// ---- serial_port_baud_generator_tb.sv ----
// Self-checking bench for the serial port bit-rate generator
`timescale 1ns/1ns
`default_nettype none

module serial_port_baud_generator_tb;
    // ==================================================================
    // Signals
    typedef struct {logic [7:0] tc; logic [7:0] dv; int smp; int bitp;} row_t;
    logic        sys_clk, rst_n, psel, penable, pwrite, pin, start;
    logic        pready, slverr, bit_tick, sample_tick, rx_level, master;
    logic        shift_empty, slv;
    logic [2:0]  rx_status, err;
    logic [7:0]  paddr, tctl, rctl;
    logic [31:0] pwdata, prdata, rd;
    int          mismatches, tests_run, p, n;
    row_t        rows [5] = '{
        '{8'h00, 8'h00, 1, 64},
        '{8'h04, 8'h02, 3, 48},
        '{8'h90, 8'h01, 2, 8},
        '{8'h94, 8'h03, 4, 16},
        '{8'h80, 8'hff, 256, 16384}};

    baud_gen baud_gen_i (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(slverr), .i_shift_empty(shift_empty),
        .i_rx_status(rx_status), .i_receive_data_pin(pin),
        .o_bit_tick(bit_tick), .o_sample_tick(sample_tick),
        .o_rx_level(rx_level), .o_clock_master(master),
        .o_transmit_control(tctl), .o_receive_control(rctl));

    shift_logic_model shift_logic_model_i (.i_sys_clk(sys_clk),
        .i_bit_tick(bit_tick), .i_start(start), .i_err(err),
        .o_shift_empty(shift_empty), .o_rx_status(rx_status));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ==================================================================
    // Tasks
    task automatic wrap_up;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] got, exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %0t %s: %h not %h", $time, msg, got, exp);
        end
    endtask : check

    // Request held until pready seen high, released after that edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Values read right after the edge are the ones that edge sampled
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            mismatches++;
            wrap_up();
        end
        rd  = prdata;
        slv = slverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Cycles from one tick to the next
    task automatic measure(input logic sel);
        n = 0;
        p = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while ((sel ? bit_tick : sample_tick) !== 1'b1 && n < 20000);
        do begin
            @(negedge sys_clk);
            p++;
        end while ((sel ? bit_tick : sample_tick) !== 1'b1 && p < 20000);
        if (n >= 20000 || p >= 20000) begin
            mismatches++;
            wrap_up();
        end
    endtask : measure

    // ==================================================================
    // Sequence
    initial begin
        {rst_n, psel, penable, pwrite, start} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        pin = 1'b1;
        err = 3'h5;
        mismatches = 0;
        tests_run = 0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        check(rx_level, 1, "idle level");
        check(tctl, 8'h02, "tc reset");
        apb(0, baud_pkg::OFS_TRANSMIT_CONTROL, 0);
        check(rd, 32'h02, "tc read");
        apb(0, baud_pkg::OFS_RECEIVE_CONTROL, 0);
        check(rd, 32'h05, "rc read");
        apb(0, baud_pkg::OFS_BAUD_DIVISOR, 0);
        check(rd, 32'h00, "div reset");
        apb(1, 8'h0c, 32'hffffffff);
        check(slv, 1, "unmapped");
        apb(1, baud_pkg::OFS_TRANSMIT_CONTROL, 32'hffffffff);
        // Master flag is registered from the stored control bits
        repeat (2) @(negedge sys_clk);
        check(master, 1, "master");
        check(tctl, 8'hf5, "tc out");
        apb(0, baud_pkg::OFS_TRANSMIT_CONTROL, 0);
        check(rd, 32'hf7, "tc mask");
        apb(1, baud_pkg::OFS_RECEIVE_CONTROL, 32'hffffffff);
        apb(0, baud_pkg::OFS_RECEIVE_CONTROL, 0);
        check(rd, 32'hfd, "rc mask");
        check(rctl, 8'hf8, "rc out");
        foreach (rows[i]) begin
            apb(1, baud_pkg::OFS_TRANSMIT_CONTROL, {24'h0, rows[i].tc});
            apb(1, baud_pkg::OFS_BAUD_DIVISOR, {24'h0, rows[i].dv});
            measure(0);
            check(p, rows[i].smp, "sample period");
            measure(1);
            check(p, rows[i].bitp, "bits");
        end
        // Slave: no ticks
        apb(1, baud_pkg::OFS_TRANSMIT_CONTROL, 32'h10);
        apb(1, baud_pkg::OFS_BAUD_DIVISOR, 32'h0);
        n = 0;
        repeat (100) begin
            @(negedge sys_clk);
            n += int'(bit_tick | sample_tick);
        end
        check(n, 0, "slave ticks");
        check(master, 0, "slave");
        // Divisor rewrite mid-count
        apb(1, baud_pkg::OFS_TRANSMIT_CONTROL, 32'h90);
        apb(1, baud_pkg::OFS_BAUD_DIVISOR, 32'hc8);
        repeat (50) @(posedge sys_clk);
        apb(1, baud_pkg::OFS_BAUD_DIVISOR, 32'h03);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (sample_tick !== 1'b1 && n < 300);
        check(n inside {[3:5]}, 1, "restart");
        // Vote: one-cycle glitch ignored, held low accepted
        apb(1, baud_pkg::OFS_BAUD_DIVISOR, 32'h0);
        @(posedge sys_clk);
        pin <= 1'b0;
        @(posedge sys_clk);
        pin <= 1'b1;
        n = 0;
        repeat (8) begin
            @(negedge sys_clk);
            n += int'(!rx_level);
        end
        check(n, 0, "glitch");
        @(posedge sys_clk);
        pin <= 1'b0;
        repeat (20) @(posedge sys_clk);
        check(rx_level, 0, "low level");
        // Shifter busy then empty
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        apb(0, baud_pkg::OFS_TRANSMIT_CONTROL, 0);
        check(rd, 32'h90, "busy");
        repeat (40) @(posedge sys_clk);
        apb(0, baud_pkg::OFS_TRANSMIT_CONTROL, 0);
        check(rd, 32'h92, "empty");
        // Reset in mid-run brings registers and outputs back
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        check({tctl, rctl}, 16'h0200, "mid reset regs");
        check({master, rx_level}, 2'b01, "mid reset outs");
        wrap_up();
    end
endmodule : serial_port_baud_generator_tb
`default_nettype wire
